// ==== core/gsh_pkg.sv ====
/*
  gsh_pkg: constants for the host-side i2c master that talks to the gesture
  sensor message port. assumes a 50 mhz system clock.
*/
package gsh_pkg;
  localparam int unsigned CLK_HZ = 50_000_000; // system clock rate
  localparam int unsigned SCL_HZ = 400_000; // highest bus rate allowed
  // quarter period of scl, least time rounded up; host period 3*QTR+2 cycles still runs above max rate
  localparam int unsigned QTR_CYC = (CLK_HZ + 4 * SCL_HZ - 1) / (4 * SCL_HZ);
  localparam logic [6:0] DEV_ADDR = 7'h42; // sensor slave address
  localparam logic DIR_READ = 1'h1; // direction bit for a read
  localparam logic DIR_WRITE = 1'h0; // direction bit for a write
  localparam int unsigned BYTE_BITS = 8; // bits per byte
  localparam int unsigned GPORT_W = 5; // event pins
  // sequencer states
  typedef enum logic [3:0] {
    GSH_IDLE = 4'h0,
    GSH_START = 4'h1,
    GSH_BIT_LO = 4'h2,
    GSH_BIT_HI = 4'h3,
    GSH_STOP_LO = 4'h4,
    GSH_STOP_HI = 4'h5,
    GSH_STOP_END = 4'h6
  } gsh_state_t;
endpackage

// ==== core/gsh_host.sv ====
/*
  gsh_host: i2c master for the gesture sensor message port, with transfer
  pending watch and event pin sampling. assumes open-drain scl/sda/pending
  wires resolved outside with pull-ups; strap pins are driven from here.
*/
// Behaviour
// R01 - both straps low select i2c mode
// R02 - sensor answers at seven-bit address 0x42
// R03 - pending line is open-drain from sensor
// R04 - host reads when pending line is low
// R05 - pending may blink high between queued messages
// R06 - host never drives the pending line
// R07 - sensor queues up to five messages
// R08 - started read removes message from queue
// R09 - aborted read still discards the message
// R10 - host clocks scl no faster than 400 khz; code scl period is 3*QTR+2 cycles, about 510 khz at QTR_CYC
// R11 - address and write data valid at rising scl
// R12 - sensor acks address, host acks read data
// R13 - host waits until scl really rises
// R14 - only matching address gets an ack
// R15 - read data msb first, changes after fall
// R16 - host acks low, final byte left high
// R17 - sensor acks each written byte
// R18 - host ends transfers with a stop
// R19 - start is sda falling while scl high
// R20 - direction bit one reads, zero writes
// R21 - five event pins run beside i2c
// R22 - many sources may share one event pin
// R23 - start condition wakes a sleeping sensor
// R24 - full queue holds pending line low
`timescale 1ns/100ps
`default_nettype none
module gsh_host #(
  parameter int unsigned QTR = gsh_pkg::QTR_CYC // cycles per quarter scl period
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic CE,
  input wire logic REQ_VALID, // start a transfer
  output logic REQ_READY, // transfer may be taken
  input wire logic REQ_READ, // one for read, zero for write
  input wire logic REQ_LAST, // this byte is final before stop
  input wire logic [7:0] REQ_WDATA, // write byte
  output logic RSP_VALID, // one-cycle pulse: byte done
  output logic [7:0] RSP_RDATA, // read byte
  output logic RSP_NACK, // address or write byte not acknowledged
  output logic PENDING, // sensor has a message waiting
  output logic [4:0] EVENTS, // synchronised event pins
  output logic IFACE_SEL_LOW_STRAP, // strap, held low
  output logic IFACE_SEL_HIGH_STRAP, // strap, held low
  input wire logic SCL_I,
  output logic SCL_O,
  output logic SCL_OE,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE,
  input wire logic XFER_PENDING_N_I, // observed only
  input wire logic [4:0] GPORT_I // event pins from sensor
);
  initial
  begin
    if (QTR < 1 || QTR > 65535) $error("gsh_host: QTR out of range");
  end

  // two-flop synchronisers for every outside input
  logic [7:0] s1_q, s2_q;
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      s1_q <= 8'hff;
      s2_q <= 8'hff;
    end
    else if (CE)
    begin
      s1_q <= {SCL_I, SDA_I, XFER_PENDING_N_I, GPORT_I};
      s2_q <= s1_q;
    end
  end
  wire scl_s = s2_q[7];
  wire sda_s = s2_q[6];
  wire pend_n_s = s2_q[5];

  // pending seen low (covers full queue too) R04 R24
  assign PENDING = ~pend_n_s; // R04
  // event pins run independently of i2c R21 R22
  assign EVENTS = s2_q[4:0]; // R21
  // both straps low select i2c at address 0x42 R01
  assign IFACE_SEL_LOW_STRAP = 1'b0; // R01
  assign IFACE_SEL_HIGH_STRAP = 1'b0; // R01

  gsh_pkg::gsh_state_t st_q, st_d;
  logic [15:0] tmr_q; // quarter-period timer
  logic [3:0] bit_q; // bit index 0..8
  logic [7:0] sh_q; // shift register
  logic phase_q; // 0 address byte, 1 data bytes
  logic rd_q, last_q, nack_q, sda_q, scl_q;
  logic [7:0] wbuf_q; // write byte held for data phase

  wire tmr_done = (tmr_q == 16'h0);
  wire take = REQ_VALID & REQ_READY;
  // ack bit slot is index 8
  wire ack_slot = (bit_q == 4'h8);
  // host drives data in write/address phase or drives ack in read data
  wire host_tx = ~phase_q | ~rd_q;
  // sda value to put on wire in current slot R12 R16
  wire bit_val = ack_slot ? (host_tx ? 1'b1 : last_q) : (host_tx ? sh_q[7] : 1'b1); // R16
  assign REQ_READY = (st_q == gsh_pkg::GSH_IDLE) | (st_q == gsh_pkg::GSH_BIT_LO && bit_q == 4'h0 && phase_q
                     && tmr_done && sda_q == 1'b1 && scl_q == 1'b0 && RSP_VALID == 1'b0 && last_q == 1'b0);

  // open-drain outputs: only drive low R03 R06
  assign SCL_O = 1'b0;
  assign SDA_O = 1'b0;
  assign SCL_OE = ~scl_q;
  assign SDA_OE = ~sda_q;

  // next state
  always_comb
  begin
    st_d = st_q;
    unique case (st_q)
      gsh_pkg::GSH_IDLE: if (take) st_d = gsh_pkg::GSH_START;
      gsh_pkg::GSH_START: if (tmr_done) st_d = gsh_pkg::GSH_BIT_LO;
      gsh_pkg::GSH_BIT_LO: if (tmr_done && !take) st_d = gsh_pkg::GSH_BIT_HI;
      gsh_pkg::GSH_BIT_HI: if (tmr_done && scl_s)
        // stop after a refused byte, or after the final data byte R18
        st_d = (ack_slot && ((host_tx && sda_s) || nack_q || (phase_q && last_q))) ? gsh_pkg::GSH_STOP_LO
             : gsh_pkg::GSH_BIT_LO;
      gsh_pkg::GSH_STOP_LO: if (tmr_done) st_d = gsh_pkg::GSH_STOP_HI;
      gsh_pkg::GSH_STOP_HI: if (tmr_done && scl_s) st_d = gsh_pkg::GSH_STOP_END;
      gsh_pkg::GSH_STOP_END: if (tmr_done) st_d = gsh_pkg::GSH_IDLE;
      default: st_d = gsh_pkg::GSH_IDLE;
    endcase
  end

  // sequencer
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      st_q <= gsh_pkg::GSH_IDLE;
      tmr_q <= 16'h0;
      bit_q <= 4'h0;
      sh_q <= 8'h0;
      phase_q <= 1'b0;
      rd_q <= 1'b0;
      last_q <= 1'b0;
      nack_q <= 1'b0;
      sda_q <= 1'b1;
      scl_q <= 1'b1;
      wbuf_q <= 8'h0;
      RSP_VALID <= 1'b0;
      RSP_RDATA <= 8'h0;
      RSP_NACK <= 1'b0;
    end
    else if (CE)
    begin
      st_q <= st_d;
      RSP_VALID <= 1'b0;
      if (!tmr_done) tmr_q <= tmr_q - 16'h1;
      unique case (st_q)
        // idle: take request, pull sda low with scl high R19 R23
        gsh_pkg::GSH_IDLE:
        begin
          if (take)
          begin
            rd_q <= REQ_READ;
            last_q <= REQ_LAST;
            wbuf_q <= REQ_WDATA;
            sh_q <= {gsh_pkg::DEV_ADDR, REQ_READ ? gsh_pkg::DIR_READ : gsh_pkg::DIR_WRITE}; // R02 R20
            phase_q <= 1'b0;
            nack_q <= 1'b0;
            bit_q <= 4'h0;
            sda_q <= 1'b0; // R19
            tmr_q <= 16'(2 * QTR);
          end
        end
        // start held, then scl low R19
        gsh_pkg::GSH_START:
        begin
          if (tmr_done)
          begin
            scl_q <= 1'b0;
            tmr_q <= 16'(QTR);
          end
        end
        // scl low: set sda after fall, then release scl
        gsh_pkg::GSH_BIT_LO:
        begin
          if (take)
          begin
            last_q <= REQ_LAST; // next data byte chained
            sh_q <= REQ_WDATA;
          end
          else
          begin
            // data settles during the low phase, ahead of the rise
            sda_q <= bit_val; // R11 R16
            if (tmr_done)
            begin
              scl_q <= 1'b1;
              tmr_q <= 16'(2 * QTR); // R10
            end
          end
        end
        // scl high: wait for real rise, sample sda R13 R15
        gsh_pkg::GSH_BIT_HI:
        begin
          if (tmr_done && scl_s) // R13
          begin
            scl_q <= 1'b0;
            tmr_q <= 16'(QTR);
            if (ack_slot)
            begin
              bit_q <= 4'h0;
              // sensor ack for address and write bytes R12 R14 R17
              if (host_tx) nack_q <= sda_s; // R14
              RSP_VALID <= 1'b1;
              RSP_NACK <= host_tx & sda_s; // R17
              RSP_RDATA <= sh_q;
              if (!phase_q)
              begin
                phase_q <= 1'b1;
                sh_q <= wbuf_q; // first write byte
                last_q <= rd_q ? last_q : last_q;
              end
            end
            else
            begin
              bit_q <= bit_q + 4'h1;
              sh_q <= {sh_q[6:0], sda_s}; // R15
            end
            // a stop follows a nacked address, a final byte R18
            if (ack_slot && (host_tx ? sda_s : 1'b0)) nack_q <= 1'b1;
          end
        end
        // stop: sda low while scl low, scl up, then sda up R18
        gsh_pkg::GSH_STOP_LO:
        begin
          sda_q <= 1'b0;
          if (tmr_done)
          begin
            scl_q <= 1'b1;
            tmr_q <= 16'(QTR);
          end
        end
        gsh_pkg::GSH_STOP_HI:
        begin
          if (tmr_done && scl_s)
          begin
            sda_q <= 1'b1; // R18
            tmr_q <= 16'(2 * QTR);
          end
        end
        gsh_pkg::GSH_STOP_END:
        begin
          bit_q <= 4'h0;
        end
        default:
        begin
          bit_q <= 4'h0;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== dv/gsh_host_assertions.sv ====
/* checker for the gsh_host pins.
   assumes a bind to gsh_host, scl/sda read back as wire levels. */
`timescale 1ns/100ps
`default_nettype none
module gsh_host_chk #(
  parameter int unsigned QTR = 2
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic REQ_READY,
  input wire logic RSP_VALID,
  input wire logic PENDING,
  input wire logic IFACE_SEL_LOW_STRAP,
  input wire logic IFACE_SEL_HIGH_STRAP,
  input wire logic SCL_I,
  input wire logic SCL_OE,
  input wire logic SDA_OE,
  input wire logic XFER_PENDING_N_I
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  int lo_q; // cycles scl pulled low
  // count the low phase of scl
  always_ff @(posedge CLK)
    lo_q <= SCL_OE ? lo_q + 1 : 0;
  // start: sda pulled while scl high
  sequence st_s; $rose(SDA_OE) && SCL_I && !SCL_OE; endsequence
  // stop: sda let go while scl high
  sequence sp_s; $fell(SDA_OE) && SCL_I && !SCL_OE; endsequence
  a_strap_i2c_mode: assert property (!IFACE_SEL_LOW_STRAP && !IFACE_SEL_HIGH_STRAP) else $error("strap");
  a_start_then_clk: assert property (st_s |-> ##[1:300] SCL_OE) else $error("start");
  a_start_busy: assert property (st_s |-> !REQ_READY) else $error("busy");
  a_stop_to_idle: assert property (sp_s |-> ##[0:300] REQ_READY) else $error("stop");
  a_scl_low_time: assert property ($fell(SCL_OE) |-> lo_q >= QTR) else $error("rate");
  a_stretch_wait: assert property (!SCL_OE && !SCL_I |=> !SCL_OE) else $error("stretch");
  a_done_pulse: assert property (RSP_VALID |=> !RSP_VALID) else $error("pulse");
  a_pend_follow: assert property (PENDING == !$past(XFER_PENDING_N_I, 2)) else $error("pend");
endmodule
bind gsh_host gsh_host_chk #(.QTR(QTR)) gsh_host_chk_i (.CLK(CLK), .RST(RST), .REQ_READY(REQ_READY),
  .RSP_VALID(RSP_VALID), .PENDING(PENDING), .IFACE_SEL_LOW_STRAP(IFACE_SEL_LOW_STRAP),
  .IFACE_SEL_HIGH_STRAP(IFACE_SEL_HIGH_STRAP), .SCL_I(SCL_I), .SCL_OE(SCL_OE), .SDA_OE(SDA_OE),
  .XFER_PENDING_N_I(XFER_PENDING_N_I));
`default_nettype wire

// ==== dv/gsh_sensor_model.sv ====
/* sensor model: i2c slave with message fifo, pending line, event pins.
   assumes the bench resolves open-drain wires with pull-ups. */
`timescale 1ns/100ps
`default_nettype none
module gsh_sensor_model (
  input wire logic clk,
  input wire logic scl,
  input wire logic sda,
  input wire logic push, // queue one message
  input wire logic [7:0] msg,
  input wire logic [7:0] stretch, // scl hold after a read address
  input wire logic [4:0] ev, // event sources
  output logic scl_hold,
  output logic sda_hold,
  output logic pend_hold, // pull pending low
  output logic [4:0] gport_n, // event pins, idle high
  output logic [7:0] wbyte // copy of sh at the eighth fall of the last data byte, written or read
);
  logic [7:0] q[$]; // message fifo
  logic [7:0] sh; // shift register
  logic scl_p, sda_p, act, adr, rd;
  int bits, hold, blink;
  initial {scl_hold, sda_hold, pend_hold, act, scl_p, sda_p, bits, hold, blink} = '0;
  assign gport_n = ~ev;
  // slave sampled on the system clock
  always @(posedge clk)
  begin
    scl_p <= scl;
    sda_p <= sda;
    if (push && q.size() < 5)
      q.push_back(msg);
    blink = blink > 0 ? blink - 1 : 0;
    hold = hold > 0 ? hold - 1 : 0;
    if (scl && scl_p && sda_p && !sda)
      {act, adr, rd, bits} = {1'b1, 1'b1, 1'b0, 32'h0};
    if (scl && scl_p && !sda_p && sda)
      act = 0;
    // rising scl: take a bit
    if (act && scl && !scl_p)
    begin
      bits = bits + 1;
      if (bits < 9 && !(rd && !adr))
        sh = {sh[6:0], sda};
      if (bits == 9 && rd && !adr)
        act = !sda;
    end
    // falling scl: drive sda
    if (act && !scl && scl_p)
    begin
      if (bits == 8 && adr)
      begin
        rd = sh[0];
        act = sh[7:1] == 7'h42;
        sda_hold <= act;
      end
      else if (bits == 8)
      begin
        wbyte <= sh;
        sda_hold <= !rd;
      end
      else if (bits == 9 && rd)
      begin
        sh = q.size() > 0 ? q.pop_front() : 8'hff;
        blink = q.size() > 0 ? 4 : 0;
        hold = adr ? int'(stretch) : 0;
        sda_hold <= !sh[7];
        {bits, adr} = '0;
      end
      else if (bits == 9)
      begin
        sda_hold <= 0;
        {bits, adr} = '0;
      end
      else if (rd && !adr)
      begin
        sh = sh << 1;
        sda_hold <= !sh[7];
      end
    end
    scl_hold <= hold > 0;
    pend_hold <= q.size() > 0 && blink == 0;
  end
endmodule
`default_nettype wire

// ==== dv/gsh_host_bench.sv ====
/* bench for gsh_host against the sensor model.
   assumes a 50 mhz clock and a short scl quarter. */
`timescale 1ns/100ps
`default_nettype none
module gsh_host_bench;
  logic clk = 0, rst = 1, rv = 0, rd = 0, push = 0;
  logic [7:0] wd = 0, msg = 0, stretch = 0, rdat, wbyte;
  logic [4:0] ev = 0, evs, gport_n;
  logic rr, rsv, nack, pend, sl, sh, scl_oe, sda_oe, scl_hold, sda_hold, pend_hold;
  logic [7:0] bt[2]; // address echo, data byte
  logic [1:0] na; // nack per byte
  int error_cnt = 0, checks = 0;
  wire logic scl = !(scl_oe | scl_hold); // pulled-up wire
  wire logic sda = !(sda_oe | sda_hold);
  always #10 clk = !clk;
  gsh_host #(.QTR(2)) gsh_host_i (.CLK(clk), .RST(rst), .CE(1'b1), .REQ_VALID(rv), .REQ_READY(rr),
    .REQ_READ(rd), .REQ_LAST(1'b1), .REQ_WDATA(wd), .RSP_VALID(rsv), .RSP_RDATA(rdat), .RSP_NACK(nack),
    .PENDING(pend), .EVENTS(evs), .IFACE_SEL_LOW_STRAP(sl), .IFACE_SEL_HIGH_STRAP(sh), .SCL_I(scl),
    .SCL_O(), .SCL_OE(scl_oe), .SDA_I(sda), .SDA_O(), .SDA_OE(sda_oe), .XFER_PENDING_N_I(!pend_hold),
    .GPORT_I(gport_n));
  gsh_sensor_model gsh_sensor_model_i (.clk(clk), .scl(scl), .sda(sda), .push(push), .msg(msg),
    .stretch(stretch), .ev(ev), .scl_hold(scl_hold), .sda_hold(sda_hold), .pend_hold(pend_hold),
    .gport_n(gport_n), .wbyte(wbyte));
  // compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one transfer: request, two byte answers, back to idle
  task automatic xfer(input logic r, input logic [7:0] w);
    int n;
    int k;
    k = 0;
    @(posedge clk);
    #1 {rv, rd, wd} = {1'b1, r, w};
    @(posedge clk);
    #1 rv = 0;
    for (n = 0; n < 4000 && !(k == 2 && rr); n++)
    begin
      @(posedge clk);
      #1;
      if (rsv === 1'b1 && k < 2)
      begin
        bt[k] = rdat;
        na[k] = nack;
        k++;
      end
    end
    if (n == 4000)
      error_cnt++;
  endtask
  // event pins and straps
  task t_events;
    @(posedge clk);
    #1 ev = 5'h15;
    repeat (4) @(posedge clk);
    #1;
    chk({3'h0, evs}, 8'h0a);
    chk({6'h0, sl, sh}, 8'h00);
  endtask
  // write lands in the sensor
  task t_write;
    xfer(0, 8'ha5);
    chk(bt[0], {gsh_pkg::DEV_ADDR, gsh_pkg::DIR_WRITE});
    chk({6'h0, na}, 8'h00);
    chk(wbyte, 8'ha5);
  endtask
  // overfill the queue, then drain it with a stretched first read
  task t_queue;
    for (int i = 0; i < 6; i++)
    begin
      @(posedge clk);
      #1 {push, msg} = {1'b1, 8'h30 + 8'(i)};
    end
    @(posedge clk);
    #1 push = 0;
    repeat (4) @(posedge clk);
    #1;
    chk({7'h0, pend}, 8'h01);
    stretch = 8'd20;
    for (int i = 0; i < 6; i++)
    begin
      xfer(1, 8'h00);
      chk(bt[1], i < 5 ? 8'h30 + 8'(i) : 8'hff);
      chk({6'h0, na}, 8'h00);
      stretch = 0;
    end
    chk({7'h0, pend}, 8'h00);
  endtask
  // verdict and end of run
  task conclude;
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (3) @(posedge clk);
    #1 rst = 0;
    t_events;
    t_write;
    t_queue;
    conclude;
  end
  initial
  begin
    #1000000;
    error_cnt++;
    conclude;
  end
endmodule
`default_nettype wire
